// ==== hdl/fpc_fifo_end.sv ====
// fifo device end: port qualification, boundary flags and offset programming
//
// What this block does
// - port A edge writes a word only with select low; write flag and serial bits move with select high too
// - port A data lines never driven, select high
// - port B edge acts with select low; floats otherwise
// - port A enable high needed for transfer
// - port B enable high needed for transfer
// - standard mode: shared read flag shows empty
// - fall-through mode: shared read flag shows output ready
// - read flag changes only on port B edges
// - standard mode: shared write flag shows full
// - fall-through mode: write flag shows input ready
// - write flag changes only on port A edges
// - reset samples offset selects and serial select
// - almost flags may lag three cycles
// - fall-through reads should be gated by ready
// - timing pin high standard, low fall-through
// - serial bit shifts in, Y msb first
// - serial programming takes 20 bit writes
// - presets 8, 16, 64 or parallel load
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fpc_fifo_end
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    fpc_link_if.dev                       link,
    output logic                          fall_through_mode,
    output logic [fpc_pkg::CNT_W-1:0]     fill_level
);
    import fpc_pkg::*;

    // storage and pointers
    logic [DATA_W-1:0]   mem [DEPTH];
    logic [PTR_W-1:0]    wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0]    rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0]    count_q, count_d;

    // output register and flags
    logic [DATA_W-1:0]   out_q, out_d;
    logic                out_valid_q, out_valid_d;
    logic                rflag_q, rflag_d;
    logic                wflag_q, wflag_d;
    logic                ae_n_q, ae_n_d;
    logic                af_n_q, af_n_d;
    logic                roe_q, roe_d;
    logic                fall_through_mode_q, fall_through_mode_d;

    // offset programming state
    fpc_method_e         method_q, method_d;
    fpc_pload_e          pload_q, pload_d;
    logic [OFS_W-1:0]    xofs_q, xofs_d;
    logic [OFS_W-1:0]    yofs_q, yofs_d;
    logic [SER_BITS-1:0] ser_q, ser_d;
    logic [SCNT_W-1:0]   scnt_q, scnt_d;

    // port clock edge detect; the controller clocks come from sys_clk flops
    logic                wclk_prev_q, rclk_prev_q;
    logic                wedge, redge;
    logic                wr_go, rd_go, push, pop, pload_busy;
    logic [DATA_W-1:0]   mem_head;
    logic [CNT_W-1:0]    free_d;

    assign wedge    = link.write_side_clock & ~wclk_prev_q;
    assign redge    = link.read_side_clock & ~rclk_prev_q;
    assign mem_head = mem[rd_ptr_q];

    // qualified port transfers
    always_comb
    begin
        wr_go      = wedge & ~link.write_port_select_n & link.write_port_enable;
        rd_go      = redge & ~link.read_port_select_n & link.read_port_enable;
        pload_busy = (method_q == MTH_PARALLEL) && (pload_q != PLD_DONE);
        // words are not taken while the parallel offsets are still loading
        push       = wr_go & ~pload_busy & (count_q != FIFO_DEPTH);
        if (fall_through_mode_q)
        begin
            // fall-through: refill the output register whenever it frees up
            pop = redge & (count_q != '0) & (~out_valid_q | rd_go);
        end
        else
        begin
            pop = rd_go & (count_q != '0);
        end
    end

    // pointers, fill count and output register
    always_comb
    begin
        wr_ptr_d    = push ? wr_ptr_q + PTR_W'(1) : wr_ptr_q;
        rd_ptr_d    = pop ? rd_ptr_q + PTR_W'(1) : rd_ptr_q;
        count_d     = count_q + CNT_W'(push) - CNT_W'(pop);
        out_d       = pop ? mem_head : out_q;
        out_valid_d = out_valid_q;
        // only a fall-through pop marks the word as waiting; a standard pop has
        // already handed it over, so it must not show as ready after a mode change
        if (pop)
        begin
            out_valid_d = fall_through_mode_q;
        end
        else if (rd_go)
        begin
            out_valid_d = 1'b0;
        end
        roe_d = ~link.read_port_select_n;
    end

    // boundary flags, each moved only by its own port clock edge
    always_comb
    begin
        rflag_d = rflag_q;
        wflag_d = wflag_q;
        ae_n_d  = ae_n_q;
        af_n_d  = af_n_q;
        free_d  = FIFO_DEPTH - count_d;
        if (redge)
        begin
            // standard: low while empty; fall-through: high while a word waits
            rflag_d = fall_through_mode_q ? out_valid_d : (count_d != '0);
            ae_n_d  = ~(count_d <= CNT_W'(xofs_q));
        end
        if (wedge)
        begin
            // both modes say high when there is room; standard reads it as full_n
            wflag_d = (count_d != FIFO_DEPTH);
            af_n_d  = ~(free_d <= CNT_W'(yofs_q));
        end
    end

    // offset programming and timing mode
    always_comb
    begin
        method_d = method_q;
        pload_d  = pload_q;
        xofs_d   = xofs_q;
        yofs_d   = yofs_q;
        ser_d    = ser_q;
        scnt_d   = scnt_q;
        fall_through_mode_d   = ~link.endian_timing_select;
        if (!rst_n)
        begin
            // method and preset are caught while reset is held
            pload_d = PLD_X;
            scnt_d  = '0;
            if (!link.serial_program_select)
            begin
                method_d = MTH_SERIAL;
            end
            else
            begin
                case ({link.offset_select1_serial_enable, link.offset_select0_serial_bit})
                    2'b00:   method_d = MTH_PARALLEL;
                    default: method_d = MTH_PRESET;
                endcase
            end
            case ({link.offset_select1_serial_enable, link.offset_select0_serial_bit})
                2'b01:   xofs_d = OFS_PRESET_8;
                2'b10:   xofs_d = OFS_PRESET_16;
                default: xofs_d = OFS_PRESET_64;
            endcase
            yofs_d = xofs_d;
        end
        else
        begin
            case (method_q)
                MTH_SERIAL:
                begin
                    // extra bits after the last one are ignored
                    if (wedge && !link.offset_select1_serial_enable && scnt_q != SER_COUNT)
                    begin
                        ser_d  = {ser_q[SER_BITS-2:0], link.offset_select0_serial_bit};
                        scnt_d = scnt_q + SCNT_W'(1);
                        if (scnt_d == SER_COUNT)
                        begin
                            yofs_d = ser_d[SER_BITS-1:OFS_W];
                            xofs_d = ser_d[OFS_W-1:0];
                        end
                    end
                end
                MTH_PARALLEL:
                begin
                    if (wr_go && pload_q == PLD_X)
                    begin
                        xofs_d  = link.write_port_data[OFS_W-1:0];
                        pload_d = PLD_Y;
                    end
                    else if (wr_go && pload_q == PLD_Y)
                    begin
                        yofs_d  = link.write_port_data[OFS_W-1:0];
                        pload_d = PLD_DONE;
                    end
                end
                MTH_PRESET:
                begin
                    pload_d = pload_q;
                end
                default:
                begin
                    method_d = MTH_PRESET;
                end
            endcase
        end
    end

    // storage write; the array holds no reset
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= link.write_port_data;
        end
    end

    // register everything; offset state takes its reset values from the comb path
    always_ff @(posedge sys_clk)
    begin
        method_q <= method_d;
        pload_q  <= pload_d;
        xofs_q   <= xofs_d;
        yofs_q   <= yofs_d;
        ser_q    <= ser_d;
        scnt_q   <= scnt_d;
        if (!rst_n)
        begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            out_q       <= '0;
            out_valid_q <= 1'b0;
            rflag_q     <= 1'b0;
            wflag_q     <= 1'b1;
            ae_n_q      <= 1'b0;
            af_n_q      <= 1'b1;
            roe_q       <= 1'b0;
            fall_through_mode_q      <= 1'b0;
        end
        else
        begin
            wclk_prev_q <= link.write_side_clock;
            rclk_prev_q <= link.read_side_clock;
            wr_ptr_q    <= wr_ptr_d;
            rd_ptr_q    <= rd_ptr_d;
            count_q     <= count_d;
            out_q       <= out_d;
            out_valid_q <= out_valid_d;
            rflag_q     <= rflag_d;
            wflag_q     <= wflag_d;
            ae_n_q      <= ae_n_d;
            af_n_q      <= af_n_d;
            roe_q       <= roe_d;
            fall_through_mode_q      <= fall_through_mode_d;
        end
    end

    // port A is an input only, so its data lines are never driven
    assign link.write_port_data_oe    = 1'b0;
    assign link.read_port_data        = out_q;
    assign link.read_port_data_oe     = roe_q;
    assign link.empty_or_output_ready = rflag_q;
    assign link.full_or_input_ready   = wflag_q;
    assign link.almost_empty_n        = ae_n_q;
    assign link.almost_full_n         = af_n_q;
    assign fall_through_mode          = fall_through_mode_q;
    assign fill_level                 = count_q;

endmodule
`default_nettype wire

// ==== hdl/fpc_pkg.sv ====
// shared constants and types for the fifo port control pair
package fpc_pkg;

    // data path and storage shape
    localparam int DATA_W   = 36;
    localparam int DEPTH    = 1024;
    localparam int PTR_W    = 10;
    localparam int CNT_W    = 11;
    localparam int OFS_W    = 10;
    localparam int SER_BITS = 2 * OFS_W;
    localparam int SCNT_W   = 5;

    localparam logic [CNT_W-1:0]  FIFO_DEPTH = 11'h400;
    localparam logic [SCNT_W-1:0] SER_COUNT  = 5'h14;

    // preset offsets for the almost flags
    localparam logic [OFS_W-1:0] OFS_PRESET_8  = 10'h008;
    localparam logic [OFS_W-1:0] OFS_PRESET_16 = 10'h010;
    localparam logic [OFS_W-1:0] OFS_PRESET_64 = 10'h040;
    localparam logic [OFS_W-1:0] OFS_RST       = 10'h040;

    // port clock divider: clock high in phases 2 and 3
    localparam int              PH_W    = 2;
    localparam logic [PH_W-1:0] PH_RISE = 2'h2;
    localparam logic [PH_W-1:0] PH_PREP = 2'h3;

    // controller register map
    localparam int              ADDR_W       = 4;
    localparam int              REG_W        = 36;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_TXDATA   = 4'h2;
    localparam logic [ADDR_W-1:0] REG_RXDATA   = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SERIAL   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] REG_INT_CLR  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_INT_EN   = 4'h7;

    // control register fields and reset value
    localparam int              CTRL_W        = 4;
    localparam int              CTRL_FALL_THROUGH_MODE_BIT = 0;
    localparam int              CTRL_SPM_BIT  = 1;
    localparam int              CTRL_FS0_BIT  = 2;
    localparam int              CTRL_FS1_BIT  = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST    = 4'hE;

    // interrupt bits
    localparam int INT_W   = 4;
    localparam int INT_RX  = 0;
    localparam int INT_TX  = 1;
    localparam int INT_SER = 2;
    localparam int INT_OVF = 3;
    localparam logic [INT_W-1:0] INT_EN_RST = 4'h0;

    // offset programming method latched at reset
    typedef enum logic [2:0]
    {
        MTH_SERIAL   = 3'b001,
        MTH_PARALLEL = 3'b010,
        MTH_PRESET   = 3'b100
    } fpc_method_e;

    // parallel offset load progress
    typedef enum logic [2:0]
    {
        PLD_X    = 3'b001,
        PLD_Y    = 3'b010,
        PLD_DONE = 3'b100
    } fpc_pload_e;

endpackage

// ==== hdl/fpc_link_if.sv ====
// pin level link between the fifo device end and its controller end
`timescale 1ns/1ps
`default_nettype none
interface fpc_link_if;
    import fpc_pkg::*;

    logic              write_side_clock;
    logic              read_side_clock;
    logic              write_port_select_n;
    logic              read_port_select_n;
    logic              write_port_enable;
    logic              read_port_enable;
    logic [DATA_W-1:0] write_port_data;
    logic              write_port_data_oe;
    logic [DATA_W-1:0] read_port_data;
    logic              read_port_data_oe;
    logic              empty_or_output_ready;
    logic              full_or_input_ready;
    logic              almost_empty_n;
    logic              almost_full_n;
    logic              endian_timing_select;
    logic              offset_select1_serial_enable;
    logic              offset_select0_serial_bit;
    logic              serial_program_select;

    // fifo device end
    modport dev
    (
        input  write_side_clock, read_side_clock,
        input  write_port_select_n, read_port_select_n,
        input  write_port_enable, read_port_enable,
        input  write_port_data, endian_timing_select,
        input  offset_select1_serial_enable, offset_select0_serial_bit, serial_program_select,
        output write_port_data_oe, read_port_data, read_port_data_oe,
        output empty_or_output_ready, full_or_input_ready, almost_empty_n, almost_full_n
    );

    // producer and consumer end
    modport ctl
    (
        output write_side_clock, read_side_clock,
        output write_port_select_n, read_port_select_n,
        output write_port_enable, read_port_enable,
        output write_port_data, endian_timing_select,
        output offset_select1_serial_enable, offset_select0_serial_bit, serial_program_select,
        input  write_port_data_oe, read_port_data, read_port_data_oe,
        input  empty_or_output_ready, full_or_input_ready, almost_empty_n, almost_full_n
    );

endinterface
`default_nettype wire

// ==== hdl/fpc_ctl_end.sv ====
// controller end: producer on port A and consumer on port B behind a register port
`timescale 1ns/1ps
`default_nettype none
module fpc_ctl_end
(
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    fpc_link_if.ctl                          link,
    input  wire logic [fpc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [fpc_pkg::REG_W-1:0]   reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [fpc_pkg::REG_W-1:0]   reg_rdata,
    output logic                             irq
);
    import fpc_pkg::*;

    logic [PH_W-1:0]     ph_q, ph_d;
    logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
    logic [DATA_W-1:0]   tx_q, tx_d, rx_q, rx_d;
    logic                tx_pend_q, tx_pend_d, rx_valid_q, rx_valid_d;
    logic                rd_iss_q, rd_iss_d;
    logic [SER_BITS-1:0] ser_q, ser_d;
    logic [SCNT_W-1:0]   scnt_q, scnt_d;
    logic                csa_n_q, csa_n_d, ena_q, ena_d, csb_n_q, csb_n_d, enb_q, enb_d;
    logic                sen_n_q, sen_n_d, sbit_q, sbit_d;
    logic [DATA_W-1:0]   adata_q, adata_d;
    logic [INT_W-1:0]    ist_q, ist_d, ien_q, ien_d, ev;
    logic [REG_W-1:0]    rdata_q, rdata_d;
    logic                irq_q, irq_d, capt, prep;

    // port activity: drives are set in phase 3 and change as the clock falls back to low
    always_comb
    begin
        ph_d       = ph_q + PH_W'(1);
        prep       = (ph_q == PH_PREP);
        // standard data follow the edge; fall-through data stand before it
        capt       = rd_iss_q & (ctrl_q[CTRL_FALL_THROUGH_MODE_BIT] ? (ph_q == PH_RISE) : prep);
        ev         = '0;
        tx_d       = tx_q;
        tx_pend_d  = tx_pend_q;
        rx_d       = capt ? link.read_port_data : rx_q;
        rx_valid_d = rx_valid_q | capt;
        rd_iss_d   = rd_iss_q & ~capt;
        ser_d      = ser_q;
        scnt_d     = scnt_q;
        csa_n_d    = csa_n_q;
        ena_d      = ena_q;
        csb_n_d    = csb_n_q;
        enb_d      = enb_q;
        sen_n_d    = sen_n_q;
        sbit_d     = sbit_q;
        adata_d    = adata_q;
        ev[INT_RX] = capt;
        if (prep)
        begin
            csa_n_d = 1'b1;
            ena_d   = 1'b0;
            sen_n_d = 1'b1;
            csb_n_d = 1'b1;
            enb_d   = 1'b0;
            if (scnt_q != '0)
            begin
                // serial bits go first, msb of the shift value first
                sen_n_d     = 1'b0;
                sbit_d      = ser_q[SER_BITS-1];
                ser_d       = {ser_q[SER_BITS-2:0], 1'b0};
                scnt_d      = scnt_q - SCNT_W'(1);
                ev[INT_SER] = (scnt_q == SCNT_W'(1));
            end
            else if (tx_pend_q && link.full_or_input_ready)
            begin
                csa_n_d    = 1'b0;
                ena_d      = 1'b1;
                adata_d    = tx_q;
                tx_pend_d  = 1'b0;
                ev[INT_TX] = 1'b1;
            end
            // fall-through reads are gated by output ready, standard by not-empty
            if (!rx_valid_q && !capt && !rd_iss_q && link.empty_or_output_ready)
            begin
                csb_n_d  = 1'b0;
                enb_d    = 1'b1;
                rd_iss_d = 1'b1;
            end
        end
        if (reg_read && reg_addr == REG_RXDATA && rx_valid_q)
        begin
            rx_valid_d = 1'b0;
        end
        ctrl_d = ctrl_q;
        ien_d  = ien_q;
        if (reg_write)
        begin
            case (reg_addr)
                REG_CTRL:   ctrl_d = reg_wdata[CTRL_W-1:0];
                REG_INT_EN: ien_d  = reg_wdata[INT_W-1:0];
                REG_TXDATA:
                begin
                    if (tx_pend_d)
                    begin
                        ev[INT_OVF] = 1'b1;
                    end
                    else
                    begin
                        tx_d      = reg_wdata[DATA_W-1:0];
                        tx_pend_d = 1'b1;
                    end
                end
                REG_SERIAL:
                begin
                    if (scnt_q == '0)
                    begin
                        ser_d  = reg_wdata[SER_BITS-1:0];
                        scnt_d = SER_COUNT;
                    end
                end
                default: ctrl_d = ctrl_q;
            endcase
        end
    end

    // sticky interrupt status: a new event beats a clear in the same cycle
    always_comb
    begin
        ist_d = ist_q;
        if (reg_write && reg_addr == REG_INT_CLR)
        begin
            ist_d = ist_q & ~reg_wdata[INT_W-1:0];
        end
        ist_d   = ist_d | ev;
        irq_d   = |(ist_d & ien_d);
        rdata_d = '0;
        if (reg_read)
        begin
            case (reg_addr)
                REG_CTRL:     rdata_d = REG_W'(ctrl_q);
                REG_STATUS:   rdata_d = REG_W'({link.almost_full_n, link.almost_empty_n, rd_iss_q,
                                                (scnt_q != '0), rx_valid_q, tx_pend_q,
                                                link.full_or_input_ready, link.empty_or_output_ready});
                REG_RXDATA:   rdata_d = REG_W'(rx_q);
                REG_INT_STAT: rdata_d = REG_W'(ist_q);
                REG_INT_EN:   rdata_d = REG_W'(ien_q);
                default:      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ph_q       <= '0;
            ctrl_q     <= CTRL_RST;
            tx_q       <= '0;
            tx_pend_q  <= 1'b0;
            rx_q       <= '0;
            rx_valid_q <= 1'b0;
            rd_iss_q   <= 1'b0;
            ser_q      <= '0;
            scnt_q     <= '0;
            csa_n_q    <= 1'b1;
            ena_q      <= 1'b0;
            csb_n_q    <= 1'b1;
            enb_q      <= 1'b0;
            // strap levels shown to the device while it is in reset
            sen_n_q    <= CTRL_RST[CTRL_FS1_BIT];
            sbit_q     <= CTRL_RST[CTRL_FS0_BIT];
            adata_q    <= '0;
            ist_q      <= '0;
            ien_q      <= INT_EN_RST;
            rdata_q    <= '0;
            irq_q      <= 1'b0;
        end
        else
        begin
            ph_q       <= ph_d;
            ctrl_q     <= ctrl_d;
            tx_q       <= tx_d;
            tx_pend_q  <= tx_pend_d;
            rx_q       <= rx_d;
            rx_valid_q <= rx_valid_d;
            rd_iss_q   <= rd_iss_d;
            ser_q      <= ser_d;
            scnt_q     <= scnt_d;
            csa_n_q    <= csa_n_d;
            ena_q      <= ena_d;
            csb_n_q    <= csb_n_d;
            enb_q      <= enb_d;
            sen_n_q    <= sen_n_d;
            sbit_q     <= sbit_d;
            adata_q    <= adata_d;
            ist_q      <= ist_d;
            ien_q      <= ien_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    assign link.write_side_clock             = ph_q[1];
    assign link.read_side_clock              = ph_q[1];
    assign link.write_port_select_n          = csa_n_q;
    assign link.write_port_enable            = ena_q;
    assign link.read_port_select_n           = csb_n_q;
    assign link.read_port_enable             = enb_q;
    assign link.write_port_data              = adata_q;
    // timing pin: high standard, low fall-through; keep it static in use
    assign link.endian_timing_select         = ~ctrl_q[CTRL_FALL_THROUGH_MODE_BIT];
    assign link.serial_program_select        = ctrl_q[CTRL_SPM_BIT];
    assign link.offset_select1_serial_enable = sen_n_q;
    assign link.offset_select0_serial_bit    = sbit_q;
    assign reg_rdata                         = rdata_q;
    assign irq                               = irq_q;

endmodule
`default_nettype wire

// ==== tb/fpc_link_checker.sv ====
// link checks: port qualification and flag timing
`timescale 1ns/1ps
`default_nettype none
module fpc_link_checker
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic write_side_clock,
    input wire logic read_side_clock,
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic write_port_enable,
    input wire logic read_port_enable,
    input wire logic write_port_data_oe,
    input wire logic read_port_data_oe,
    input wire logic empty_or_output_ready,
    input wire logic full_or_input_ready,
    input wire logic endian_timing_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // qualified port A edge; port clocks are slow so the low phase precedes it
    sequence a_go;
        !write_side_clock ##1 (write_side_clock && !write_port_select_n && write_port_enable);
    endsequence
    a_float_a: assert property (write_port_select_n |-> !write_port_data_oe)
        else $error("A data driven");
    b_float_a: assert property (read_port_data_oe == !$past(read_port_select_n))
        else $error("B enable wrong");
    rd_edge_a: assert property (!$stable(empty_or_output_ready) |->
        $past(read_side_clock) && !$past(read_side_clock, 2)) else $error("read flag off edge");
    wr_edge_a: assert property (!$stable(full_or_input_ready) |->
        $past(write_side_clock) && !$past(write_side_clock, 2)) else $error("write flag off edge");
    wr_fill_a: assert property (a_go ##0 (full_or_input_ready && endian_timing_select) |=>
        empty_or_output_ready) else $error("empty after write");
    no_fill_a: assert property ($rose(empty_or_output_ready) && endian_timing_select |->
        !$past(write_port_select_n) && $past(write_port_enable)) else $error("fill without write");
    rd_drop_a: assert property ($fell(empty_or_output_ready) |->
        !$past(read_port_select_n) && $past(read_port_enable)) else $error("drain without read");
    wr_drop_a: assert property ($fell(full_or_input_ready) |->
        !$past(write_port_select_n) && $past(write_port_enable)) else $error("full without write");
endmodule
`default_nettype wire

// ==== tb/tb_fifo_port_control_and_flags.sv ====
// bench: controller end drives the fifo end over the link
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_port_control_and_flags;
    import fpc_pkg::*;
    logic              sys_clk = 1'h0;
    logic              rst_n = 1'h0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [REG_W-1:0]  reg_wdata = '0;
    logic              reg_write = 1'h0;
    logic              reg_read = 1'h0;
    logic [REG_W-1:0]  reg_rdata;
    logic              irq;
    logic              ftm;
    int                error_cnt = 0;
    int                num_checks = 0;
    fpc_link_if lnk ();
    // 40 ns period
    always #20 sys_clk = ~sys_clk;
    // the two ends face each other; fill level is not looked at
    fpc_fifo_end i_fpc_fifo_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk),
        .fall_through_mode(ftm), .fill_level());
    fpc_ctl_end i_fpc_ctl_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
    fpc_link_checker i_fpc_link_checker (.sys_clk(sys_clk), .rst_n(rst_n), .write_side_clock(lnk.write_side_clock),
        .read_side_clock(lnk.read_side_clock), .write_port_select_n(lnk.write_port_select_n),
        .read_port_select_n(lnk.read_port_select_n), .write_port_enable(lnk.write_port_enable),
        .read_port_enable(lnk.read_port_enable), .write_port_data_oe(lnk.write_port_data_oe),
        .read_port_data_oe(lnk.read_port_data_oe), .empty_or_output_ready(lnk.empty_or_output_ready),
        .full_or_input_ready(lnk.full_or_input_ready), .endian_timing_select(lnk.endian_timing_select));
    task automatic chk(input string what, input logic [REG_W-1:0] exp, input logic [REG_W-1:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_write <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog far beyond the roughly 80 cycles the tests need
    initial
    begin
        #800000;
        error_cnt++;
        close_out();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'h1;
        rc(REG_STATUS, 36'h82, "status");
        chk("mode", 36'h0, {35'h0, ftm});
        rc(4'hF, 36'h0, "unmapped");
        $display("test reset done");
        wr(REG_INT_EN, 36'hF);
        // second word lands while the first is pending, so it is refused
        @(posedge sys_clk);
        reg_addr <= REG_TXDATA;
        reg_wdata <= 36'h9A5C30F1E;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_wdata <= 36'h012345678;
        @(posedge sys_clk);
        reg_write <= 1'h0;
        repeat (24) @(posedge sys_clk);
        rc(REG_INT_STAT, 36'hB, "int stat");
        chk("irq", 36'h1, {35'h0, irq});
        rc(REG_RXDATA, 36'h9A5C30F1E, "rx word");
        wr(REG_INT_CLR, 36'hF);
        rc(REG_INT_STAT, 36'h0, "int clear");
        chk("irq clear", 36'h0, {35'h0, irq});
        $display("test transfer done");
        wr(REG_CTRL, 36'h1);
        wr(REG_INT_EN, 36'h0);
        wr(REG_TXDATA, 36'hFEDCBA987);
        repeat (24) @(posedge sys_clk);
        chk("mode", 36'h1, {35'h0, ftm});
        chk("irq masked", 36'h0, {35'h0, irq});
        rc(REG_INT_STAT, 36'h3, "int fall_through_mode");
        rc(REG_RXDATA, 36'hFEDCBA987, "rx fall_through_mode");
        $display("test fall-through done");
        close_out();
    end
endmodule
`default_nettype wire
